/* vic_pkg.sv */
// vic_pkg: register map, field positions, vectors and states for the interrupt controller
package vic_pkg;
    localparam logic [2:0] ADDR_IRQ_CTL0  = 3'h0;
    localparam logic [2:0] ADDR_IRQ_CTL1  = 3'h1;
    localparam logic [2:0] ADDR_MF_CTL    = 3'h2;
    localparam logic [2:0] ADDR_MISC_CTL  = 3'h3;
    localparam logic [2:0] ADDR_STATUS    = 3'h4;

    localparam logic [7:0] RST_IRQ_CTL0   = 8'h00;
    localparam logic [7:0] RST_IRQ_CTL1   = 8'h00;
    localparam logic [7:0] RST_MF_CTL     = 8'h00;
    localparam logic [7:0] RST_MISC_CTL   = 8'h00;

    localparam logic [7:0] MASK_IRQ_CTL0  = 8'h7f;
    localparam logic [7:0] MASK_IRQ_CTL1  = 8'h66;
    localparam logic [7:0] MASK_MF_CTL    = 8'h77;
    localparam logic [7:0] MASK_MISC_CTL  = 8'hc8;

    localparam int C0_GIE  = 0;
    localparam int C0_EXE  = 1;
    localparam int C0_T0E  = 2;
    localparam int C0_T1E  = 3;
    localparam int C0_EXF  = 4;
    localparam int C0_T0F  = 5;
    localparam int C0_T1F  = 6;
    localparam int C1_TBE  = 1;
    localparam int C1_MFE  = 2;
    localparam int C1_TBF  = 5;
    localparam int C1_MFF  = 6;
    localparam int MF_CE   = 0;
    localparam int MF_A0E  = 1;
    localparam int MF_A1E  = 2;
    localparam int MF_CF   = 4;
    localparam int MF_A0F  = 5;
    localparam int MF_A1F  = 6;
    localparam int MS_DIR3 = 3;
    localparam int MS_ELO  = 6;
    localparam int MS_EHI  = 7;

    localparam logic [11:0] VEC_EXT   = 12'h004;
    localparam logic [11:0] VEC_TMR0  = 12'h008;
    localparam logic [11:0] VEC_TMR1  = 12'h00c;
    localparam logic [11:0] VEC_TBASE = 12'h014;
    localparam logic [11:0] VEC_MFUNC = 12'h018;

    localparam int SYS_PER_INSTR  = 4;
    localparam int ENTRY_CYC_RUN  = 2;
    localparam int ENTRY_CYC_WAKE = 3;

    typedef enum logic [3:0] {
        VIC_IDLE  = 4'b0001,
        VIC_WAIT  = 4'b0010,
        VIC_CALL  = 4'b0100,
        VIC_SLEEP = 4'b1000
    } vic_state_t;

    typedef struct packed {
        logic        ext_pin;
        logic        tmr0_ovf;
        logic        tmr1_ovf;
        logic        tbase_ovf;
        logic        opamp_zero_out;
        logic        opamp_one_out;
        logic        cmp_edge;
    } vic_src_t;

    typedef struct packed {
        logic        stack_full;
        logic        instr_bound;
        logic        halted;
    } vic_core_in_t;

    typedef struct packed {
        logic        call_req;
        logic [11:0] call_vec;
        logic        wake;
    } vic_core_out_t;
endpackage : vic_pkg

/* vic_top.sv */
// vic_top: vectored interrupt request, priority and call logic
`timescale 1ns/1ps
module vic_top #(
    parameter int ADDR_W = 3
) (
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [7:0]                reg_rdata,
    input  wire vic_pkg::vic_src_t    src,
    input  wire vic_pkg::vic_core_in_t core_in,
    output vic_pkg::vic_core_out_t    core_out,
    output logic                      port_a_line_three_is_input,
    output logic                      port_a_line_three_pullup_keep
);
    initial begin
        if (ADDR_W < 3) $error("vic_top: ADDR_W must be at least 3");
    end

    default clocking vic_clk_cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    logic [7:0]  ctl0_q, ctl0_d;
    logic [7:0]  ctl1_q, ctl1_d;
    logic [7:0]  mfc_q, mfc_d;
    logic [7:0]  misc_q;
    logic [7:0]  rdata_q;
    logic        pin_q, opamp_zero_q, opamp_one_q;
    logic [7:0]  cnt_q;
    vic_pkg::vic_state_t st_q, st_d;
    logic [11:0] vec_q;
    logic [2:0]  sel_q;
    logic        woke_q;

    function automatic logic wr_hit(input logic [ADDR_W-1:0] a, input logic [2:0] r);
        wr_hit = reg_wr && (a == ADDR_W'(r));
    endfunction : wr_hit

    // edge decode
    wire logic [1:0] edge_sel    = {misc_q[vic_pkg::MS_EHI], misc_q[vic_pkg::MS_ELO]};
    wire logic       pin_rise    = src.ext_pin && !pin_q;
    wire logic       pin_fall    = !src.ext_pin && pin_q;
    wire logic       ext_evt     = (edge_sel[0] && pin_rise) || (edge_sel[1] && pin_fall);
    wire logic       opamp_zero_evt    = opamp_zero_q && !src.opamp_zero_out;
    wire logic       opamp_one_evt    = opamp_one_q && !src.opamp_one_out;
    wire logic       cmp_evt     = src.cmp_edge;

    wire logic       w0 = wr_hit(reg_addr, vic_pkg::ADDR_IRQ_CTL0);
    wire logic       w1 = wr_hit(reg_addr, vic_pkg::ADDR_IRQ_CTL1);
    wire logic       wm = wr_hit(reg_addr, vic_pkg::ADDR_MF_CTL);
    wire logic       wx = wr_hit(reg_addr, vic_pkg::ADDR_MISC_CTL);

    // sub-source flags feeding the multi-function flag
    wire logic       a0_set  = opamp_zero_evt && mfc_q[vic_pkg::MF_A0E];
    wire logic       a1_set  = opamp_one_evt && mfc_q[vic_pkg::MF_A1E];
    wire logic       cf_set  = cmp_evt && mfc_q[vic_pkg::MF_CE];
    wire logic       mf_set  = a0_set || a1_set || cf_set;

    // pending requests, priority order low index first
    wire logic       gie = ctl0_q[vic_pkg::C0_GIE];
    wire logic [4:0] pend = {
        ctl1_q[vic_pkg::C1_MFF] && ctl1_q[vic_pkg::C1_MFE],
        ctl1_q[vic_pkg::C1_TBF] && ctl1_q[vic_pkg::C1_TBE],
        ctl0_q[vic_pkg::C0_T1F] && ctl0_q[vic_pkg::C0_T1E],
        ctl0_q[vic_pkg::C0_T0F] && ctl0_q[vic_pkg::C0_T0E],
        ctl0_q[vic_pkg::C0_EXF] && ctl0_q[vic_pkg::C0_EXE]};
    wire logic       any_req = gie && (pend != 5'h0);
    wire logic       accept  = any_req && !core_in.stack_full && core_in.instr_bound;
    wire logic [2:0] win = pend[0] ? 3'h0 : pend[1] ? 3'h1 : pend[2] ? 3'h2 :
                           pend[3] ? 3'h3 : 3'h4;
    wire logic [11:0] win_vec = (win == 3'h0) ? vic_pkg::VEC_EXT :
                                (win == 3'h1) ? vic_pkg::VEC_TMR0 :
                                (win == 3'h2) ? vic_pkg::VEC_TMR1 :
                                (win == 3'h3) ? vic_pkg::VEC_TBASE :
                                vic_pkg::VEC_MFUNC;
    wire logic       serve = (st_q == vic_pkg::VIC_CALL);
    wire logic       wake_src = (pend != 5'h0);

    // flag update: hardware set beats software clear; service clears
    always_comb begin
        ctl0_d = w0 ? (reg_wdata & vic_pkg::MASK_IRQ_CTL0) : ctl0_q;
        ctl1_d = w1 ? (reg_wdata & vic_pkg::MASK_IRQ_CTL1) : ctl1_q;
        mfc_d  = wm ? (reg_wdata & vic_pkg::MASK_MF_CTL) : mfc_q;
        if (serve) begin
            ctl0_d[vic_pkg::C0_GIE] = 1'b0;
            case (sel_q)
                3'h0:    ctl0_d[vic_pkg::C0_EXF] = 1'b0;
                3'h1:    ctl0_d[vic_pkg::C0_T0F] = 1'b0;
                3'h2:    ctl0_d[vic_pkg::C0_T1F] = 1'b0;
                3'h3:    ctl1_d[vic_pkg::C1_TBF] = 1'b0;
                default: ctl1_d[vic_pkg::C1_MFF] = 1'b0;
            endcase
        end
        if (ext_evt)         ctl0_d[vic_pkg::C0_EXF] = 1'b1;
        if (src.tmr0_ovf)    ctl0_d[vic_pkg::C0_T0F] = 1'b1;
        if (src.tmr1_ovf)    ctl0_d[vic_pkg::C0_T1F] = 1'b1;
        if (src.tbase_ovf)   ctl1_d[vic_pkg::C1_TBF] = 1'b1;
        if (mf_set)          ctl1_d[vic_pkg::C1_MFF] = 1'b1;
        if (a0_set)          mfc_d[vic_pkg::MF_A0F]  = 1'b1;
        if (a1_set)          mfc_d[vic_pkg::MF_A1F]  = 1'b1;
        if (cf_set)          mfc_d[vic_pkg::MF_CF]   = 1'b1;
    end

    // entry sequencer
    always_comb begin
        st_d = st_q;
        case (st_q)
            vic_pkg::VIC_IDLE:  begin
                if (core_in.halted && wake_src) st_d = vic_pkg::VIC_SLEEP;
                else if (accept)                st_d = vic_pkg::VIC_WAIT;
            end
            vic_pkg::VIC_SLEEP: st_d = vic_pkg::VIC_IDLE;
            vic_pkg::VIC_WAIT:  begin
                if (cnt_q == 8'h00) st_d = vic_pkg::VIC_CALL;
            end
            vic_pkg::VIC_CALL:  st_d = vic_pkg::VIC_IDLE;
            default:            st_d = vic_pkg::VIC_IDLE;
        endcase
    end

    localparam logic [7:0] RUN_CYC  = 8'(vic_pkg::ENTRY_CYC_RUN * vic_pkg::SYS_PER_INSTR - 2);
    localparam logic [7:0] WAKE_CYC = 8'(vic_pkg::ENTRY_CYC_WAKE * vic_pkg::SYS_PER_INSTR - 2);

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ctl0_q <= vic_pkg::RST_IRQ_CTL0;
            ctl1_q <= vic_pkg::RST_IRQ_CTL1;
            mfc_q  <= vic_pkg::RST_MF_CTL;
            misc_q <= vic_pkg::RST_MISC_CTL;
        end else begin
            ctl0_q <= ctl0_d;
            ctl1_q <= ctl1_d;
            mfc_q  <= mfc_d;
            if (wx) misc_q <= reg_wdata & vic_pkg::MASK_MISC_CTL;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pin_q  <= 1'b0;
            opamp_zero_q <= 1'b0;
            opamp_one_q <= 1'b0;
        end else begin
            pin_q  <= src.ext_pin;
            opamp_zero_q <= src.opamp_zero_out;
            opamp_one_q <= src.opamp_one_out;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_q   <= vic_pkg::VIC_IDLE;
            cnt_q  <= 8'h00;
            vec_q  <= 12'h000;
            sel_q  <= 3'h0;
            woke_q <= 1'b0;
        end else begin
            st_q <= st_d;
            if (st_q == vic_pkg::VIC_SLEEP) woke_q <= 1'b1;
            if (st_q == vic_pkg::VIC_IDLE && st_d == vic_pkg::VIC_WAIT) begin
                cnt_q  <= woke_q ? WAKE_CYC : RUN_CYC;
                vec_q  <= win_vec;
                sel_q  <= win;
                woke_q <= 1'b0;
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end

    // register read, one cycle later
    wire logic [7:0] rd_mux =
        (reg_addr == ADDR_W'(vic_pkg::ADDR_IRQ_CTL0)) ? ctl0_q :
        (reg_addr == ADDR_W'(vic_pkg::ADDR_IRQ_CTL1)) ? ctl1_q :
        (reg_addr == ADDR_W'(vic_pkg::ADDR_MF_CTL))   ? mfc_q  :
        (reg_addr == ADDR_W'(vic_pkg::ADDR_MISC_CTL)) ? misc_q :
        (reg_addr == ADDR_W'(vic_pkg::ADDR_STATUS))   ? {4'h0, st_q} : 8'h00;

    always_ff @(posedge ref_clk) begin
        if (!nrst) rdata_q <= 8'h00;
        else       rdata_q <= reg_rd ? rd_mux : 8'h00;
    end

    assign reg_rdata                     = rdata_q;
    // only the pc push is requested of the core; nothing else is saved
    assign core_out.call_req             = serve;
    assign core_out.call_vec             = vec_q;
    assign core_out.wake                 = core_in.halted && wake_src;
    assign port_a_line_three_is_input    = misc_q[vic_pkg::MS_DIR3];
    assign port_a_line_three_pullup_keep = 1'b1;

    a_call_clears_gie: assert property (
        serve
        |=> !ctl0_q[vic_pkg::C0_GIE])
        else $error("global enable not cleared on call");

    a_no_accept_full: assert property (
        (st_q == vic_pkg::VIC_IDLE && core_in.stack_full)
        |=> st_q != vic_pkg::VIC_WAIT)
        else $error("accepted while stack full");

    a_ext_vector: assert property (
        (serve && sel_q == 3'h0)
        |-> vec_q == vic_pkg::VEC_EXT)
        else $error("bad ext vector");

    a_t0_vector: assert property (
        (serve && sel_q == 3'h1)
        |-> vec_q == vic_pkg::VEC_TMR0)
        else $error("bad timer0 vector");

    a_t1_vector: assert property (
        (serve && sel_q == 3'h2)
        |-> vec_q == vic_pkg::VEC_TMR1)
        else $error("bad timer1 vector");

    a_tb_vector: assert property (
        (serve && sel_q == 3'h3)
        |-> vec_q == vic_pkg::VEC_TBASE)
        else $error("bad time base vector");

    a_mf_vector: assert property (
        (serve && sel_q == 3'h4)
        |-> vec_q == vic_pkg::VEC_MFUNC)
        else $error("bad mf vector");

    a_ext_flag_set: assert property (
        ext_evt
        |=> ctl0_q[vic_pkg::C0_EXF])
        else $error("ext flag missed");

    a_edge_off: assert property (
        (edge_sel == 2'b00 && !ctl0_q[vic_pkg::C0_EXF] && !w0)
        |=> !ctl0_q[vic_pkg::C0_EXF])
        else $error("ext flag set with edges off");

    a_t0_set: assert property (
        src.tmr0_ovf
        |=> ctl0_q[vic_pkg::C0_T0F])
        else $error("timer0 flag missed");

    a_t1_set: assert property (
        src.tmr1_ovf
        |=> ctl0_q[vic_pkg::C0_T1F])
        else $error("timer1 flag missed");

    a_tb_set: assert property (
        src.tbase_ovf
        |=> ctl1_q[vic_pkg::C1_TBF])
        else $error("time base flag missed");

    a_flag_holds: assert property (
        (ctl0_q[vic_pkg::C0_T0F] && !w0 && !serve)
        |=> ctl0_q[vic_pkg::C0_T0F])
        else $error("timer0 flag dropped");

    a_ext_clear: assert property (
        (serve && sel_q == 3'h0 && !ext_evt)
        |=> !ctl0_q[vic_pkg::C0_EXF])
        else $error("ext flag kept after call");

    a_t0_clear: assert property (
        (serve && sel_q == 3'h1 && !src.tmr0_ovf)
        |=> !ctl0_q[vic_pkg::C0_T0F])
        else $error("timer0 flag kept after call");

    a_t1_clear: assert property (
        (serve && sel_q == 3'h2 && !src.tmr1_ovf)
        |=> !ctl0_q[vic_pkg::C0_T1F])
        else $error("timer1 flag kept after call");

    a_tb_clear: assert property (
        (serve && sel_q == 3'h3 && !src.tbase_ovf)
        |=> !ctl1_q[vic_pkg::C1_TBF])
        else $error("time base flag kept after call");

    a_mf_clear: assert property (
        (serve && sel_q == 3'h4 && !mf_set)
        |=> !ctl1_q[vic_pkg::C1_MFF])
        else $error("mf flag kept after call");

    a_mf_from_sub: assert property (
        a0_set
        |=> ctl1_q[vic_pkg::C1_MFF] && mfc_q[vic_pkg::MF_A0F])
        else $error("mf flag missed");

    a_sub_gate: assert property (
        (opamp_one_evt && !mfc_q[vic_pkg::MF_A1E] && !mfc_q[vic_pkg::MF_A1F] && !wm)
        |=> !mfc_q[vic_pkg::MF_A1F])
        else $error("sub flag set while its enable is off");

    a_no_gie: assert property (
        (st_q == vic_pkg::VIC_IDLE && !gie)
        |=> st_q != vic_pkg::VIC_WAIT)
        else $error("accepted with global enable off");

    a_at_bound: assert property (
        (st_q == vic_pkg::VIC_IDLE && !core_in.instr_bound)
        |=> st_q != vic_pkg::VIC_WAIT)
        else $error("accepted off an instruction boundary");

    a_prio_ext: assert property (
        (st_q == vic_pkg::VIC_IDLE && accept && !core_in.halted && pend[0])
        |=> sel_q == 3'h0)
        else $error("external not served first");

    a_prio_t0: assert property (
        (st_q == vic_pkg::VIC_IDLE && accept && !core_in.halted && pend[1:0] == 2'b10)
        |=> sel_q == 3'h1)
        else $error("timer0 priority wrong");

    a_prio_t1: assert property (
        (st_q == vic_pkg::VIC_IDLE && accept && !core_in.halted && pend[2:0] == 3'b100)
        |=> sel_q == 3'h2)
        else $error("timer1 priority wrong");

    a_call_pulse: assert property (
        serve
        |=> !serve)
        else $error("call request longer than one cycle");

    a_rd_unmapped: assert property (
        (reg_rd && reg_addr > ADDR_W'(vic_pkg::ADDR_STATUS))
        |=> reg_rdata == 8'h00)
        else $error("unmapped address read non-zero");

    sequence s_enter;
        st_q == vic_pkg::VIC_IDLE ##1 st_q == vic_pkg::VIC_WAIT;
    endsequence

    sequence s_run_enter;
        !woke_q && st_q == vic_pkg::VIC_IDLE ##1 st_q == vic_pkg::VIC_WAIT;
    endsequence

    sequence s_wake_enter;
        woke_q && st_q == vic_pkg::VIC_IDLE ##1 st_q == vic_pkg::VIC_WAIT;
    endsequence

    a_entry_time: assert property (
        s_enter
        |-> ##[7:11] serve)
        else $error("entry latency out of range");

    a_run_latency: assert property (
        s_run_enter
        |-> ##7 serve)
        else $error("run entry latency wrong");

    a_wake_latency: assert property (
        s_wake_enter
        |-> ##11 serve)
        else $error("wake entry latency wrong");

    a_unimpl_zero: assert property (
        ((ctl0_q & ~vic_pkg::MASK_IRQ_CTL0) | (ctl1_q & ~vic_pkg::MASK_IRQ_CTL1) |
         (mfc_q & ~vic_pkg::MASK_MF_CTL) | (misc_q & ~vic_pkg::MASK_MISC_CTL)) == 8'h00)
        else $error("unimplemented bit set");
endmodule : vic_top

/* vic_core_model.sv */
// vic_core_model: behavioural core sequencer and call stack beside the controller
`timescale 1ns/1ps
module vic_core_model #(
    parameter int STACK_DEPTH = 4
) (
    input  wire logic                   ref_clk,
    input  wire logic                   nrst,
    input  wire vic_pkg::vic_core_out_t core_out,
    input  wire logic                   ret_pulse,
    input  wire logic                   sleep,
    output vic_pkg::vic_core_in_t       core_in
);
    int unsigned depth_q;
    int unsigned phase_q;

    assign core_in.stack_full  = (depth_q >= STACK_DEPTH);
    assign core_in.instr_bound = (phase_q == 0);
    assign core_in.halted      = sleep;

    always @(posedge ref_clk) begin
        if (!nrst) begin
            depth_q <= 0;
            phase_q <= 0;
        end else begin
            phase_q <= (phase_q + 1) % vic_pkg::SYS_PER_INSTR;
            // only the return address goes on the stack; service code makes no calls
            if (core_out.call_req === 1'b1) begin
                depth_q <= depth_q + 1;
            end else if (ret_pulse && depth_q > 0) begin
                depth_q <= depth_q - 1;
            end
        end
    end
endmodule : vic_core_model

/* tb_vic_top.sv */
// tb_vic_top: self-checking bench for the interrupt controller
`timescale 1ns/1ps
module tb_vic_top;
    logic                   ref_clk = 0;
    logic                   nrst = 0;
    logic [2:0]             reg_addr = 0;
    logic [7:0]             reg_wdata = 0;
    logic                   reg_wr = 0;
    logic                   reg_rd = 0;
    logic [7:0]             reg_rdata;
    vic_pkg::vic_src_t      src = '0;
    vic_pkg::vic_core_in_t  core_in;
    vic_pkg::vic_core_out_t core_out;
    logic                   pin_in;
    logic                   pull_keep;
    logic                   ret_pulse = 0;
    logic                   sleep = 0;
    logic                   rd_d = 0;
    logic [7:0]             rd_q[$];
    logic [11:0]            vec_q[$];
    int                     mismatches = 0;
    int                     cmp_count = 0;
    int                     cyc = 0;
    int                     seed = 51257;
    int                     i;
    logic [7:0]             d;
    logic [7:0]             c0;
    logic [7:0]             masks[4] = '{vic_pkg::MASK_IRQ_CTL0, vic_pkg::MASK_IRQ_CTL1,
                                         vic_pkg::MASK_MF_CTL, vic_pkg::MASK_MISC_CTL};
    logic [11:0]            vecs[5] = '{vic_pkg::VEC_EXT, vic_pkg::VEC_TMR0, vic_pkg::VEC_TMR1,
                                        vic_pkg::VEC_TBASE, vic_pkg::VEC_MFUNC};
    logic [7:0]             c0_after[4] = '{8'h6e, 8'h4e, 8'h0e, 8'h0e};

    always #2.5 ref_clk = ~ref_clk;

    vic_top i_vic_top (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .src(src), .core_in(core_in), .core_out(core_out),
        .port_a_line_three_is_input(pin_in), .port_a_line_three_pullup_keep(pull_keep));
    vic_core_model i_vic_core_model (.ref_clk(ref_clk), .nrst(nrst), .core_out(core_out),
        .ret_pulse(ret_pulse), .sleep(sleep), .core_in(core_in));

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t data got %h exp %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t vector got %h exp %h", $time, got, exp);
        end
    endtask : chk12

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_wr    <= 1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd   <= 1;
        reg_addr <= a;
        rd_q.push_back(e);
        @(posedge ref_clk);
        reg_rd <= 0;
        tick(1);
    endtask : rd

    task automatic wait_calls();
        int n;
        n = 0;
        while (vec_q.size() > 0 && n < 200) begin
            tick(1);
            n++;
        end
        if (vec_q.size() > 0) begin
            mismatches++;
            $display("[ERR] %0t call never came", $time);
        end
    endtask : wait_calls

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    // results watcher: read data and vectored calls against the notes
    always @(posedge ref_clk) begin
        rd_d <= reg_rd;
        if (rd_d) begin
            chk8(reg_rdata, rd_q.pop_front());
        end
        if (core_out.call_req === 1'b1) begin
            if (vec_q.size() == 0) begin
                mismatches++;
                $display("[ERR] %0t unexpected call %h", $time, core_out.call_vec);
            end else begin
                chk12(core_out.call_vec, vec_q.pop_front());
            end
        end
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            test_done();
        end
    end

    initial begin
        tick(5);
        nrst <= 1;
        for (i = 0; i < 6; i++) begin
            rd(i[2:0], (i == 4) ? 8'h01 : 8'h00);
        end
        for (i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            if (i[1:0] == 0) d[0] = 0;
            wr(i[2:0] & 3'h3, d);
            rd(i[2:0] & 3'h3, d & masks[i[1:0]]);
        end
        wr(3'h5, 8'hff);
        rd(3'h5, 8'h00);
        for (i = 0; i < 4; i++) wr(i[2:0], 8'h00);
        // each edge code, flag held while the global enable is off
        for (i = 0; i < 4; i++) begin
            wr(3'h3, {i[1:0], 6'h08});
            wr(3'h0, 8'h02);
            src.ext_pin <= 1;
            tick(2);
            rd(3'h0, i[0] ? 8'h12 : 8'h02);
            wr(3'h0, 8'h02);
            src.ext_pin <= 0;
            tick(2);
            rd(3'h0, i[1] ? 8'h12 : 8'h02);
            wr(3'h0, 8'h02);
        end
        chk8({6'h0, pin_in, pull_keep}, 8'h03);
        // all five sources pending at once
        wr(3'h3, 8'h48);
        wr(3'h0, 8'h0e);
        wr(3'h1, 8'h06);
        wr(3'h2, 8'h02);
        src.opamp_zero_out <= 1;
        tick(2);
        src <= '{ext_pin: 1, tmr0_ovf: 1, tmr1_ovf: 1, tbase_ovf: 1, default: 0};
        tick(1);
        src <= '{ext_pin: 1, default: 0};
        tick(2);
        rd(3'h0, 8'h7e);
        rd(3'h1, 8'h66);
        rd(3'h2, 8'h22);
        sleep <= 1;
        tick(2);
        chk8({7'h0, core_out.wake}, 8'h01);
        sleep <= 0;
        c0 = 8'h7f;
        for (i = 0; i < 4; i++) begin
            vec_q.push_back(vecs[i]);
            wr(3'h0, c0 | 8'h01);
            wait_calls();
            c0 = c0_after[i];
            rd(3'h0, c0);
        end
        rd(3'h1, 8'h46);
        wr(3'h0, 8'h0f);
        tick(40);
        vec_q.push_back(vecs[4]);
        ret_pulse <= 1;
        tick(1);
        ret_pulse <= 0;
        wait_calls();
        rd(3'h1, 8'h06);
        rd(3'h2, 8'h22);
        rd(3'h0, 8'h0e);
        // sub-source gating, then op-amp one and comparator sources
        wr(3'h2, 8'h01);
        src.opamp_one_out <= 1;
        tick(2);
        src.opamp_one_out <= 0;
        tick(2);
        rd(3'h2, 8'h01);
        rd(3'h1, 8'h06);
        wr(3'h2, 8'h07);
        src.opamp_one_out <= 1;
        tick(2);
        src <= '{ext_pin: 1, cmp_edge: 1, default: 0};
        tick(1);
        src <= '{ext_pin: 1, default: 0};
        tick(2);
        rd(3'h2, 8'h57);
        rd(3'h1, 8'h46);
        test_done();
    end
endmodule : tb_vic_top
